// *** src/hci_uart_pkg.sv ***
// Shared constants and types for the HCI UART transport and its host partner.
// Assumes a single 50 MHz system clock on both ends of the link.
package hci_uart_pkg;
    // ==========================================================
    // Widths and sizes.
    localparam int CNT_W = 13;
    localparam int PTR_W = 11;
    localparam int ADDR_W = 12;
    localparam int FIFO_DEPTH = 1040;
    localparam int RTS_MARGIN = 16;
    typedef logic [CNT_W-1:0] cnt_t;
    typedef logic [PTR_W-1:0] ptr_t;
    // ==========================================================
    // Port clock generation from the system clock, figures in MHz.
    localparam logic [6:0] SYS_CLK_MHZ = 7'h32;
    localparam logic [6:0] PORT_CLK_LO_MHZ = 7'h18;
    localparam logic [6:0] PORT_CLK_HI_MHZ = 7'h30;
    // ==========================================================
    // Bit timing.
    localparam int BASE_SHIFT = 4;
    localparam logic [4:0] HIGH_RATE_BASE = 5'h10;
    localparam logic [3:0] MAX_STUFF = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h9;
    // ==========================================================
    // Register offsets, byte addresses of aligned words.
    localparam logic [ADDR_W-1:0] OFS_DIVISOR = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_ADJUST = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_DATA = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
    // ==========================================================
    // Reset values: 115200 bit/s from a 24 MHz port clock.
    localparam logic [7:0] DIVISOR_RST = 8'h0D;
    localparam logic [15:0] ADJUST_RST = 16'h0000;
    // ==========================================================
    // Field positions.
    localparam int CTRL_CLK48 = 0;
    localparam int CTRL_HIGH_RATE = 1;
    localparam int ST_TX_CNT_LSB = 16;
    localparam int ST_RX_OVF = 29;
    localparam int ST_TX_OVF = 30;
    localparam int ST_FRAME_ERR = 31;
endpackage

// *** src/hci_uart_if.sv ***
// Four-wire serial link between the controller end and the host end.
// Both ends run on the same system clock; each samples the other's lines.
`timescale 1ns/1ps
interface hci_uart_if;
    logic dev_txd;
    logic host_txd;
    logic dev_rts_n;
    logic host_rts_n;
    modport device (output dev_txd, output dev_rts_n, input host_txd, input host_rts_n);
    modport host (input dev_txd, input dev_rts_n, output host_txd, output host_rts_n);
endinterface

// *** src/uart_serial_engine.sv ***
// One character serialiser and deserialiser: start bit, eight data bits, stop bit.
// Assumes tick_in marks port-clock cycles and bit timing is stable per character.
`timescale 1ns/1ps
module uart_serial_engine (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    // Bit timing in port-clock cycles.
    input wire hci_uart_pkg::cnt_t half_in,
    input wire hci_uart_pkg::cnt_t bit_in,
    // Transmit side.
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_ready_out,
    output logic txd_out,
    // Receive side.
    input wire logic rxd_in,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic rx_err_out
);
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RECV = 2'b10} rx_state_t;
    tx_state_t tx_state_r;
    rx_state_t rx_state_r;
    logic [8:0] tx_shift_r;
    logic [3:0] tx_bit_r;
    logic [3:0] rx_bit_r;
    hci_uart_pkg::cnt_t tx_cnt_r;
    hci_uart_pkg::cnt_t rx_cnt_r;
    logic [7:0] rx_shift_r;
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic rxf_r;
    logic rxf_d_r;

    assign tx_ready_out = (tx_state_r == TX_IDLE);

    // ==========================================================
    // Transmitter.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_state_r <= TX_IDLE;
            txd_out <= 1'b1;
            tx_shift_r <= '1;
            tx_bit_r <= '0;
            tx_cnt_r <= '0;
        end else begin
            unique case (tx_state_r)
                TX_IDLE: begin
                    if (tx_valid_in) begin
                        txd_out <= 1'b0;
                        tx_shift_r <= {1'b1, tx_data_in};
                        tx_bit_r <= '0;
                        tx_cnt_r <= '0;
                        tx_state_r <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tick_in) begin
                        if (tx_cnt_r == bit_in - 1'b1) begin
                            tx_cnt_r <= '0;
                            if (tx_bit_r == hci_uart_pkg::LAST_BIT) begin
                                tx_state_r <= TX_IDLE;
                            end else begin
                                txd_out <= tx_shift_r[0];
                                tx_shift_r <= {1'b1, tx_shift_r[8:1]};
                                tx_bit_r <= tx_bit_r + 1'b1;
                            end
                        end else begin
                            tx_cnt_r <= tx_cnt_r + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Receive line filter: a level counts once the last two stages agree.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            rxf_r <= 1'b1;
            rxf_d_r <= 1'b1;
        end else begin
            s1_r <= rxd_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                rxf_r <= s3_r;
            end
            rxf_d_r <= rxf_r;
        end
    end

    // ==========================================================
    // Receiver, sampling each bit at the end of its first half.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_state_r <= RX_IDLE;
            rx_bit_r <= '0;
            rx_cnt_r <= '0;
            rx_shift_r <= '0;
            rx_data_out <= '0;
            rx_valid_out <= 1'b0;
            rx_err_out <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            rx_err_out <= 1'b0;
            unique case (rx_state_r)
                RX_IDLE: begin
                    if (rxf_d_r && !rxf_r) begin
                        rx_cnt_r <= '0;
                        rx_bit_r <= '0;
                        rx_state_r <= RX_RECV;
                    end
                end
                RX_RECV: begin
                    if (tick_in) begin
                        rx_cnt_r <= (rx_cnt_r == bit_in - 1'b1) ? '0 : rx_cnt_r + 1'b1;
                        if (rx_cnt_r == bit_in - 1'b1) begin
                            rx_bit_r <= rx_bit_r + 1'b1;
                        end
                        if (rx_cnt_r == half_in - 1'b1) begin
                            if (rx_bit_r == '0 && rxf_r) begin
                                rx_state_r <= RX_IDLE;
                            end else if (rx_bit_r == hci_uart_pkg::LAST_BIT) begin
                                rx_data_out <= rx_shift_r;
                                rx_valid_out <= 1'b1;
                                rx_err_out <= !rxf_r;
                                rx_state_r <= RX_IDLE;
                            end else if (rx_bit_r != '0) begin
                                rx_shift_r <= {rxf_r, rx_shift_r[7:1]};
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule

// *** src/hci_uart_device.sv ***
// Controller end of the HCI serial transport: APB registers, two byte queues,
// port-clock generation and bit timing. Assumes APB master on the same clock.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module hci_uart_device (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // APB slave.
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [hci_uart_pkg::ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Serial link.
    hci_uart_if.device LINK
);
    logic [7:0] div_r;
    logic [15:0] adj_r;
    logic clk48_r;
    logic high_rate_r;
    logic [6:0] acc_r;
    logic [7:0] sum;
    logic tick;
    logic [7:0] div_eff;
    logic [3:0] stuff_first;
    logic [3:0] stuff_end;
    hci_uart_pkg::cnt_t base;
    hci_uart_pkg::cnt_t bit_cyc;
    hci_uart_pkg::cnt_t half_cyc;
    logic apb_done;
    logic wr_done;
    logic rd_done;
    logic mapped;
    logic [7:0] rx_mem [0:hci_uart_pkg::FIFO_DEPTH-1];
    logic [7:0] tx_mem [0:hci_uart_pkg::FIFO_DEPTH-1];
    hci_uart_pkg::ptr_t rx_wr_r;
    hci_uart_pkg::ptr_t rx_rd_r;
    hci_uart_pkg::ptr_t rx_cnt_r;
    hci_uart_pkg::ptr_t tx_wr_r;
    hci_uart_pkg::ptr_t tx_rd_r;
    hci_uart_pkg::ptr_t tx_cnt_r;
    logic rx_push;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic rx_ovf_r;
    logic tx_ovf_r;
    logic frame_err_r;
    logic c1_r;
    logic c2_r;
    logic c3_r;
    logic cts_ok_r;
    logic eng_tx_ready;
    logic [7:0] eng_rx_data;
    logic eng_rx_valid;
    logic eng_rx_err;
    logic [31:0] status;

    function automatic hci_uart_pkg::ptr_t next_ptr(input hci_uart_pkg::ptr_t p);
        next_ptr = (p == hci_uart_pkg::PTR_W'(hci_uart_pkg::FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // ==========================================================
    // APB access: one wait state, so read data always comes from a flip-flop.
    assign apb_done = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign wr_done = apb_done && PWRITE_IN;
    assign rd_done = apb_done && !PWRITE_IN;
    assign mapped = (PADDR_IN == hci_uart_pkg::OFS_DIVISOR) ||
                    (PADDR_IN == hci_uart_pkg::OFS_ADJUST) ||
                    (PADDR_IN == hci_uart_pkg::OFS_CONTROL) ||
                    (PADDR_IN == hci_uart_pkg::OFS_DATA) ||
                    (PADDR_IN == hci_uart_pkg::OFS_STATUS);

    always_comb begin
        status = '0;
        status[hci_uart_pkg::PTR_W-1:0] = rx_cnt_r;
        status[hci_uart_pkg::ST_TX_CNT_LSB +: hci_uart_pkg::PTR_W] = tx_cnt_r;
        status[hci_uart_pkg::ST_RX_OVF] = rx_ovf_r;
        status[hci_uart_pkg::ST_TX_OVF] = tx_ovf_r;
        status[hci_uart_pkg::ST_FRAME_ERR] = frame_err_r;
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
            if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
                PSLVERR_OUT <= !mapped;
                PRDATA_OUT <= 32'h0000_0000;
                unique case (PADDR_IN)
                    hci_uart_pkg::OFS_DIVISOR: PRDATA_OUT[7:0] <= div_r;
                    hci_uart_pkg::OFS_ADJUST: PRDATA_OUT[15:0] <= adj_r;
                    hci_uart_pkg::OFS_CONTROL: begin
                        PRDATA_OUT[hci_uart_pkg::CTRL_CLK48] <= clk48_r;
                        PRDATA_OUT[hci_uart_pkg::CTRL_HIGH_RATE] <= high_rate_r;
                    end
                    hci_uart_pkg::OFS_DATA: PRDATA_OUT[7:0] <= rx_mem[rx_rd_r];
                    hci_uart_pkg::OFS_STATUS: PRDATA_OUT <= status;
                    default: PRDATA_OUT <= 32'h0000_0000;
                endcase
            end else begin
                PSLVERR_OUT <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Rate settings. Software rewrites them on the host's rate command.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            div_r <= hci_uart_pkg::DIVISOR_RST;
            adj_r <= hci_uart_pkg::ADJUST_RST;
            clk48_r <= 1'b0;
            high_rate_r <= 1'b0;
        end else if (wr_done) begin
            if (PADDR_IN == hci_uart_pkg::OFS_DIVISOR) begin
                div_r <= PWDATA_IN[7:0];
            end
            if (PADDR_IN == hci_uart_pkg::OFS_ADJUST) begin
                adj_r <= PWDATA_IN[15:0];
            end
            if (PADDR_IN == hci_uart_pkg::OFS_CONTROL) begin
                clk48_r <= PWDATA_IN[hci_uart_pkg::CTRL_CLK48];
                high_rate_r <= PWDATA_IN[hci_uart_pkg::CTRL_HIGH_RATE];
            end
        end
    end

    // ==========================================================
    // Port clock: a phase accumulator marks 24 or 48 of every 50 system cycles.
    // The marks jitter by one system cycle, well inside the error budget.
    assign sum = {1'b0, acc_r} + {1'b0, clk48_r ? hci_uart_pkg::PORT_CLK_HI_MHZ :
                                 hci_uart_pkg::PORT_CLK_LO_MHZ};
    assign tick = (sum >= {1'b0, hci_uart_pkg::SYS_CLK_MHZ});

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            acc_r <= '0;
        end else begin
            acc_r <= tick ? 7'(sum - {1'b0, hci_uart_pkg::SYS_CLK_MHZ}) : sum[6:0];
        end
    end

    // ==========================================================
    // Bit timing. High-rate mode shortens a sixteen-cycle bit by the low nibble.
    assign div_eff = (div_r == '0) ? 8'h01 : div_r;
    assign stuff_first = (adj_r[11:8] > hci_uart_pkg::MAX_STUFF) ?
                         hci_uart_pkg::MAX_STUFF : adj_r[11:8];
    assign stuff_end = (adj_r[15:12] > hci_uart_pkg::MAX_STUFF) ?
                       hci_uart_pkg::MAX_STUFF : adj_r[15:12];
    assign base = high_rate_r ?
        hci_uart_pkg::cnt_t'(hci_uart_pkg::HIGH_RATE_BASE - {1'b0, adj_r[3:0]}) :
        hci_uart_pkg::cnt_t'({div_eff, 4'h0});
    assign bit_cyc = high_rate_r ? base :
        base + hci_uart_pkg::cnt_t'(stuff_first) + hci_uart_pkg::cnt_t'(stuff_end);
    assign half_cyc = high_rate_r ? (base >> 1) :
        (base >> 1) + hci_uart_pkg::cnt_t'(stuff_first);

    // ==========================================================
    // Clear-to-send filter.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            c1_r <= 1'b1;
            c2_r <= 1'b1;
            c3_r <= 1'b1;
            cts_ok_r <= 1'b0;
        end else begin
            c1_r <= LINK.host_rts_n;
            c2_r <= c1_r;
            c3_r <= c2_r;
            if (c2_r == c3_r) begin
                cts_ok_r <= !c3_r;
            end
        end
    end

    // ==========================================================
    // Queues. A character already started is finished even if CTS drops.
    assign rx_push = eng_rx_valid && !eng_rx_err &&
                     (rx_cnt_r != hci_uart_pkg::PTR_W'(hci_uart_pkg::FIFO_DEPTH));
    assign rx_pop = rd_done && (PADDR_IN == hci_uart_pkg::OFS_DATA) && (rx_cnt_r != '0);
    assign tx_push = wr_done && (PADDR_IN == hci_uart_pkg::OFS_DATA) &&
                     (tx_cnt_r != hci_uart_pkg::PTR_W'(hci_uart_pkg::FIFO_DEPTH));
    assign tx_pop = eng_tx_ready && cts_ok_r && (tx_cnt_r != '0);

    always_ff @(posedge CLK_IN) begin
        if (rx_push) begin
            rx_mem[rx_wr_r] <= eng_rx_data;
        end
        if (tx_push) begin
            tx_mem[tx_wr_r] <= PWDATA_IN[7:0];
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            rx_wr_r <= '0;
            rx_rd_r <= '0;
            rx_cnt_r <= '0;
            tx_wr_r <= '0;
            tx_rd_r <= '0;
            tx_cnt_r <= '0;
        end else begin
            if (rx_push) begin
                rx_wr_r <= next_ptr(rx_wr_r);
            end
            if (rx_pop) begin
                rx_rd_r <= next_ptr(rx_rd_r);
            end
            rx_cnt_r <= rx_cnt_r + (rx_push ? 1'b1 : 1'b0) - (rx_pop ? 1'b1 : 1'b0);
            if (tx_push) begin
                tx_wr_r <= next_ptr(tx_wr_r);
            end
            if (tx_pop) begin
                tx_rd_r <= next_ptr(tx_rd_r);
            end
            tx_cnt_r <= tx_cnt_r + (tx_push ? 1'b1 : 1'b0) - (tx_pop ? 1'b1 : 1'b0);
        end
    end

    // ==========================================================
    // Sticky errors: write one to clear; a new event in the same cycle wins.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            rx_ovf_r <= 1'b0;
            tx_ovf_r <= 1'b0;
            frame_err_r <= 1'b0;
        end else begin
            if (wr_done && PADDR_IN == hci_uart_pkg::OFS_STATUS) begin
                rx_ovf_r <= rx_ovf_r && !PWDATA_IN[hci_uart_pkg::ST_RX_OVF];
                tx_ovf_r <= tx_ovf_r && !PWDATA_IN[hci_uart_pkg::ST_TX_OVF];
                frame_err_r <= frame_err_r && !PWDATA_IN[hci_uart_pkg::ST_FRAME_ERR];
            end
            if (eng_rx_valid && !eng_rx_err && !rx_push) begin
                rx_ovf_r <= 1'b1;
            end
            if (wr_done && PADDR_IN == hci_uart_pkg::OFS_DATA && !tx_push) begin
                tx_ovf_r <= 1'b1;
            end
            if (eng_rx_valid && eng_rx_err) begin
                frame_err_r <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Request-to-send: released early enough that the host's last bytes fit.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            LINK.dev_rts_n <= 1'b1;
        end else begin
            LINK.dev_rts_n <= (rx_cnt_r >= hci_uart_pkg::PTR_W'(hci_uart_pkg::FIFO_DEPTH -
                                hci_uart_pkg::RTS_MARGIN));
        end
    end

    uart_serial_engine engine (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .tick_in(tick),
        .half_in(half_cyc),
        .bit_in(bit_cyc),
        .tx_valid_in(tx_pop),
        .tx_data_in(tx_mem[tx_rd_r]),
        .tx_ready_out(eng_tx_ready),
        .txd_out(LINK.dev_txd),
        .rxd_in(LINK.host_txd),
        .rx_data_out(eng_rx_data),
        .rx_valid_out(eng_rx_valid),
        .rx_err_out(eng_rx_err)
    );
endmodule

// *** src/hci_uart_host.sv ***
// Host end of the HCI serial transport: one character at a time, no queue.
// Assumes the user sets the bit period in system clock cycles to match the device.
`timescale 1ns/1ps
module hci_uart_host (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // Bit period in system clock cycles.
    input wire hci_uart_pkg::cnt_t BIT_CYCLES_IN,
    // Transmit request.
    input wire logic [7:0] TX_DATA_IN,
    input wire logic TX_VALID_IN,
    output logic TX_READY_OUT,
    // Received characters.
    input wire logic RX_READY_IN,
    output logic [7:0] RX_DATA_OUT,
    output logic RX_VALID_OUT,
    output logic RX_ERR_OUT,
    // Serial link.
    hci_uart_if.host LINK
);
    logic c1_r;
    logic c2_r;
    logic c3_r;
    logic cts_ok_r;
    logic eng_ready;

    // ==========================================================
    // Flow control. Boot-phase rate limits are up to whoever sets the period.
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            c1_r <= 1'b1;
            c2_r <= 1'b1;
            c3_r <= 1'b1;
            cts_ok_r <= 1'b0;
        end else begin
            c1_r <= LINK.dev_rts_n;
            c2_r <= c1_r;
            c3_r <= c2_r;
            if (c2_r == c3_r) begin
                cts_ok_r <= !c3_r;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            LINK.host_rts_n <= 1'b1;
        end else begin
            LINK.host_rts_n <= !RX_READY_IN;
        end
    end

    assign TX_READY_OUT = eng_ready && cts_ok_r;

    uart_serial_engine engine (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .tick_in(1'b1),
        .half_in(BIT_CYCLES_IN >> 1),
        .bit_in(BIT_CYCLES_IN),
        .tx_valid_in(TX_VALID_IN && cts_ok_r),
        .tx_data_in(TX_DATA_IN),
        .tx_ready_out(eng_ready),
        .txd_out(LINK.host_txd),
        .rxd_in(LINK.dev_txd),
        .rx_data_out(RX_DATA_OUT),
        .rx_valid_out(RX_VALID_OUT),
        .rx_err_out(RX_ERR_OUT)
    );
endmodule

// *** testbench/hci_uart_link_sva.sv ***
// Checker on the four link lines between the two ends.
// Assumes both ends share CLK_IN and the synchronous SYS_RST_IN.
`timescale 1ns/1ps
module hci_uart_link_sva (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // Link lines.
    input wire logic dev_txd,
    input wire logic host_txd,
    input wire logic dev_rts_n,
    input wire logic host_rts_n
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    // ====
    // Every rate used here gives at least eight clocks a bit, so shorter runs are glitches.
    sequence s_dev_low;
        !dev_txd [*8];
    endsequence
    sequence s_dev_high;
        dev_txd [*8];
    endsequence
    AST_RST_DEV: assert property ($fell(SYS_RST_IN) |-> dev_txd && dev_rts_n)
        else $error("device lines not idle after reset");
    AST_RST_HOST: assert property ($fell(SYS_RST_IN) |-> host_txd && host_rts_n)
        else $error("host lines not idle after reset");
    AST_RTS_EMPTY: assert property ($fell(SYS_RST_IN) |-> ##[1:3] !dev_rts_n)
        else $error("device not ready to receive after reset");
    AST_RTS_STEADY: assert property ($fell(dev_rts_n) |=> !dev_rts_n [*4])
        else $error("device ready line glitched");
    AST_DEV_LOW: assert property ($fell(dev_txd) |=> s_dev_low)
        else $error("device low bit too short");
    AST_DEV_HIGH: assert property ($rose(dev_txd) |=> s_dev_high)
        else $error("device high bit too short");
    AST_HOST_LOW: assert property ($fell(host_txd) |=> !host_txd [*8])
        else $error("host low bit too short");
    AST_HOST_HIGH: assert property ($rose(host_txd) |=> host_txd [*8])
        else $error("host high bit too short");
endmodule

// *** testbench/hci_uart_baud_transport_test.sv ***
// Bench joining device and host ends over the link; APB and host ports driven here.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module hci_uart_baud_transport_test;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, tx_ready, rx_valid, rx_err;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data;
    hci_uart_pkg::cnt_t bits = 13'h01B2;
    int errors = 0;
    int checks_done = 0;
    // ====
    // Rate table: control, divisor, adjustment, host bit period in clocks.
    logic [1:0] ctl [5] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1};
    logic [7:0] dvs [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h1A};
    logic [15:0] adj [5] = '{16'hFFF8, 16'hFFF4, 16'h44FF, 16'h00FF, 16'h01E6};
    logic [12:0] cyc [5] = '{13'h0011, 13'h0019, 13'h0032, 13'h0011, 13'h01B2};
    always #10 clk_in = ~clk_in;
    hci_uart_if hci_uart_if_i ();
    hci_uart_device hci_uart_device_i (.CLK_IN(clk_in), .SYS_RST_IN(rst_in), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINK(hci_uart_if_i));
    hci_uart_host hci_uart_host_i (.CLK_IN(clk_in), .SYS_RST_IN(rst_in), .BIT_CYCLES_IN(bits),
        .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid), .TX_READY_OUT(tx_ready),
        .RX_READY_IN(rx_ready), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid),
        .RX_ERR_OUT(rx_err), .LINK(hci_uart_if_i));
    hci_uart_link_sva hci_uart_link_sva_i (.CLK_IN(clk_in), .SYS_RST_IN(rst_in),
        .dev_txd(hci_uart_if_i.dev_txd), .host_txd(hci_uart_if_i.host_txd),
        .dev_rts_n(hci_uart_if_i.dev_rts_n), .host_rts_n(hci_uart_if_i.host_rts_n));
    task automatic end_of_test();
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hang();
        errors++;
        end_of_test();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        logic ok;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        // Sampled mid-cycle, so the values are the ones the next rising edge sees.
        do begin
            @(negedge clk_in);
            ok = pready;
            rd = prdata;
            err = pslverr;
            @(posedge clk_in);
            n++;
            if (n > 20) hang();
        end while (ok !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic host_get(input logic [7:0] e);
        int n = 0;
        do begin
            @(negedge clk_in);
            n++;
            if (n > 20000) hang();
        end while (rx_valid !== 1'b1);
        `CHK("host rx data", e, rx_data)
        `CHK("host rx error", 1'b0, rx_err)
        @(posedge clk_in);
    endtask
    task automatic xfer(input logic [7:0] b);
        int n = 0;
        logic ok;
        apb(1'b1, hci_uart_pkg::OFS_DATA, {24'h00_0000, b});
        host_get(b);
        tx_data <= ~b;
        tx_valid <= 1'b1;
        do begin
            @(negedge clk_in);
            ok = tx_ready;
            @(posedge clk_in);
            n++;
            if (n > 20000) hang();
        end while (ok !== 1'b1);
        tx_valid <= 1'b0;
        n = 0;
        do begin
            apb(1'b0, hci_uart_pkg::OFS_STATUS, 32'h0000_0000);
            n++;
            if (n > 5000) hang();
        end while (rd[10:0] === 11'h000);
        `CHK("rx count", 11'h001, rd[10:0])
        apb(1'b0, hci_uart_pkg::OFS_DATA, 32'h0000_0000);
        `CHK("device rx data", ~b, rd[7:0])
        // The host's stop bit must end before its bit period may change.
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
            if (n > 20000) hang();
        end while (tx_ready !== 1'b1);
        @(posedge clk_in);
    endtask
    initial begin
        int lows = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        apb(1'b0, hci_uart_pkg::OFS_DIVISOR, 32'h0000_0000);
        `CHK("divisor reset", hci_uart_pkg::DIVISOR_RST, rd[7:0])
        apb(1'b0, hci_uart_pkg::OFS_ADJUST, 32'h0000_0000);
        `CHK("adjust reset", hci_uart_pkg::ADJUST_RST, rd[15:0])
        apb(1'b0, 12'h014, 32'hFFFF_FFFF);
        `CHK("unmapped error", 1'b1, err)
        // Host not ready: the queued byte must wait in the queue, with the line idle, until it is.
        rx_ready <= 1'b0;
        repeat (20) @(posedge clk_in);
        apb(1'b1, hci_uart_pkg::OFS_DATA, 32'h0000_00C3);
        repeat (600) begin
            @(posedge clk_in);
            lows += (hci_uart_if_i.dev_txd !== 1'b1);
        end
        `CHK("held while blocked", 0, lows)
        rx_ready <= 1'b1;
        host_get(8'hC3);
        xfer(8'hA5);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, hci_uart_pkg::OFS_CONTROL, {30'h0, ctl[i]});
            apb(1'b1, hci_uart_pkg::OFS_DIVISOR, {24'h00_0000, dvs[i]});
            apb(1'b1, hci_uart_pkg::OFS_ADJUST, {16'h0000, adj[i]});
            apb(1'b0, hci_uart_pkg::OFS_ADJUST, 32'h0000_0000);
            `CHK("adjust rewrite", adj[i], rd[15:0])
            bits <= cyc[i];
            xfer(8'h5A ^ 8'(i));
        end
        end_of_test();
    end
endmodule
